// *** core/pdc_pkg.sv ***
/*
  Constants, register offsets, reset values and the sequencer state type for the power-down and control-mode block.
  Assumes a single 100 MHz clock and a synchronous active-low reset in every user.
*/
package pdc_pkg;
  // ----------------------------------------
  // Serial frame layout
  // ----------------------------------------
  localparam int          FRAME_BITS  = 32;
  localparam int          ADDR_MSB    = 19;
  localparam int          ADDR_LSB    = 16;
  localparam logic [11:0] HEADER      = 12'h001;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [3:0]  A_CONFIG    = 4'h1;
  localparam logic [3:0]  A_I_OFFSET  = 4'h2;
  localparam logic [3:0]  A_I_FSCALE  = 4'h3;
  localparam logic [3:0]  A_Q_OFFSET  = 4'hA;
  localparam logic [3:0]  A_Q_FSCALE  = 4'hB;
  localparam logic [3:0]  A_DE_ENABLE = 4'hD;
  localparam logic [3:0]  A_DE_COARSE = 4'hE;
  localparam logic [3:0]  A_DE_FINE   = 4'hF;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_CONFIG  = 16'hB2FF;
  localparam logic [15:0] RST_OFFSET  = 16'h007F;
  localparam logic [15:0] RST_FSCALE  = 16'h807F;
  localparam logic [15:0] RST_DE_EN   = 16'h3FFF;
  localparam logic [15:0] RST_DE_CRS  = 16'h07FF;
  localparam logic [15:0] RST_DE_FINE = 16'h001C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int          B_PHASE     = 11;
  localparam int          B_NDDR      = 10;
  localparam int          B_SWING     = 9;
  localparam int          B_EDGE      = 8;
  localparam int          B_DE_ON     = 15;
  localparam int          B_DE_AUTO   = 14;
  localparam int          B_DE_QSEL   = 13;
  localparam int          B_VAL_MSB   = 15;
  localparam int          B_VAL_LSB   = 7;
  // ----------------------------------------
  // Calibration timing (in clock cycles)
  // ----------------------------------------
  localparam int          CAL_CYCLES  = 1400;
  localparam int          DLY_SHORT   = 1024;
  localparam int          DLY_LONG    = 65536;
  localparam int          CNT_W       = 17;
  typedef enum logic [1:0] {ST_WAIT, ST_DELAY, ST_CAL, ST_RUN} pdc_state_t;
endpackage

// *** core/pdc_serial_if.sv ***
/*
  Interface carrying decoded register writes from the serial receiver to the controller.
  Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface pdc_serial_if;
  logic       wr_stb;  // One-cycle write strobe
  logic [3:0] wr_addr; // Register address
  logic [15:0] wr_data; // Register value
  modport rx  (output wr_stb, output wr_addr, output wr_data);
  modport ctl (input wr_stb, input wr_addr, input wr_data);
endinterface
`default_nettype wire

// *** core/pdc_serial_rx.sv ***
/*
  Serial register-write receiver: 32-bit frames, MSB first, header then address then data.
  Assumes serial pins are synchronous to the core clock; edge of serial clock detected here.
*/
`timescale 1ns/1ps
`default_nettype none
module pdc_serial_rx
  import pdc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic ser_sel_n,
  pdc_serial_if.rx  wr
);
  logic [31:0] shift_q;  // Frame shifter
  logic [5:0]  count_q;  // Bits received
  logic        sclk_q;   // Previous serial clock level
  logic        rise;     // Serial clock rising edge
  assign rise = ser_clk & ~sclk_q;
  // ----------------------------------------
  // Shift and frame count
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_q <= 32'h0;
      count_q <= 6'h0;
      sclk_q  <= 1'b0;
    end else begin
      sclk_q <= ser_clk;
      if (!enable || ser_sel_n) begin
        count_q <= 6'h0; // Interface idle outside extended mode
      end else if (rise) begin
        shift_q <= {shift_q[30:0], ser_data};
        // Back-to-back frames restart at the 33rd edge
        count_q <= (count_q == 6'(FRAME_BITS)) ? 6'h1 : count_q + 6'h1;
      end
    end
  end
  // ----------------------------------------
  // Write strobe after a full frame, repeated every other cycle while serial clock stays high
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr.wr_stb  <= 1'b0;
      wr.wr_addr <= 4'h0;
      wr.wr_data <= 16'h0;
    end else begin
      wr.wr_stb  <= 1'b0;
      if (enable && count_q == 6'(FRAME_BITS) && !rise && sclk_q == ser_clk && shift_q[31:20] == HEADER
          && wr.wr_stb == 1'b0 && ser_clk) begin
        wr.wr_stb  <= 1'b1;
        wr.wr_addr <= shift_q[ADDR_MSB:ADDR_LSB];
        wr.wr_data <= shift_q[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// *** core/pdc_ctrl.sv ***
/*
  Power-down sequencing and normal/extended control-mode selection for a dual-channel converter.
  Assumes static control pins synchronous to the 100 MHz clock; holds the eight write-only registers.
*/
`timescale 1ns/1ps
`default_nettype none
module pdc_ctrl
  import pdc_pkg::*;
#(
  parameter int CAL_LEN   = CAL_CYCLES, // Calibration length
  parameter int SHORT_DLY = DLY_SHORT,  // Short power-on delay
  parameter int LONG_DLY  = DLY_LONG    // Long power-on delay
)(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        power_down_pin,
  input  wire logic        q_channel_power_down,
  input  wire logic        range_or_ext_ctrl_select,
  input  wire logic        ext_select_float,
  input  wire logic        ddr_pin_float,
  input  wire logic        edge_pin,
  input  wire logic        output_swing_select,
  input  wire logic        cal_delay_des_pin,
  input  wire logic        cal_request,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_sel_n,
  output logic             active,
  output logic             i_powered,
  output logic             q_powered,
  output logic             data_oe,
  output logic             clk_or_pulldown,
  output logic             cal_busy,
  output logic             cal_done,
  output logic             q_calibrated,
  output logic             double_rate,
  output logic             ddr_phase_90,
  output logic             rising_edge_out,
  output logic             swing_high,
  output logic             range_high,
  output logic [8:0]       i_range_trim,
  output logic [8:0]       q_range_trim,
  output logic [8:0]       i_offset_trim,
  output logic [8:0]       q_offset_trim,
  output logic             dual_edge_on,
  output logic             dual_edge_q_input,
  output logic             dual_edge_auto_phase,
  output logic [15:0]      dual_edge_coarse,
  output logic [15:0]      dual_edge_fine
);
  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  // Signal groups in this module:
  //   sequencer state and counter
  //   pending power-down latch
  //   eight write-only register images
  //   registered power and feature outputs
  // Every output is a flop so that pin levels
  // never glitch while the mode muxes settle.
  // Decoded serial writes arrive on this bundle
  pdc_serial_if sif ();
  pdc_state_t   state_q;        // Sequencer state
  logic [CNT_W-1:0] cnt_q;      // Delay and calibration counter
  logic         pd_q;           // Powered-down state
  logic         pend_q;         // Power-down waiting on calibration
  logic         ext;            // Extended control active
  logic [15:0]  cfg_q, ioff_q, ifs_q, qoff_q, qfs_q, den_q, dcrs_q, dfin_q;
  // Extended mode is the float level on the select pin
  assign ext = ext_select_float;
  // Trim field shared by range and offset registers
  // Upper nine bits carry the step value;
  // low bits are padding and ignored here.
  // Used four times, hence a function
  function automatic logic [8:0] trim(input logic [15:0] v);
    trim = v[B_VAL_MSB:B_VAL_LSB];
  endfunction
  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  pdc_serial_rx u_rx (
    .clock     (clock),
    .rst_n     (rst_n),
    .enable    (ext),
    .ser_clk   (ser_clk),
    .ser_data  (ser_data),
    .ser_sel_n (ser_sel_n),
    .wr        (sif.rx)
  );
  // ----------------------------------------
  // Write-only register file
  // ----------------------------------------
  // Reset values give the extended-mode defaults
  // Writes only land in extended mode; in normal
  // mode the receiver is held idle anyway, the
  // extra gate guards against a stray strobe.
  // No read path exists: registers are write-only,
  // so the images are only visible through the
  // feature outputs below.
  // Reserved addresses fall through untouched.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_q  <= RST_CONFIG;
      ioff_q <= RST_OFFSET;
      ifs_q  <= RST_FSCALE;
      qoff_q <= RST_OFFSET;
      qfs_q  <= RST_FSCALE;
      den_q  <= RST_DE_EN;
      dcrs_q <= RST_DE_CRS;
      dfin_q <= RST_DE_FINE;
    end else if (sif.wr_stb && ext) begin
      unique case (sif.wr_addr)
        A_CONFIG:    cfg_q  <= sif.wr_data;
        A_I_OFFSET:  ioff_q <= sif.wr_data;
        A_I_FSCALE:  ifs_q  <= sif.wr_data;
        A_Q_OFFSET:  qoff_q <= sif.wr_data;
        A_Q_FSCALE:  qfs_q  <= sif.wr_data;
        A_DE_ENABLE: den_q  <= sif.wr_data;
        A_DE_COARSE: dcrs_q <= sif.wr_data;
        A_DE_FINE:   dfin_q <= sif.wr_data;
        default: ;                          // Reserved addresses dropped
      endcase
    end
  end
  // ----------------------------------------
  // Power-down and calibration sequencer
  // ----------------------------------------
  // Power-down entry never cuts a calibration short
  // State walk:
  //   WAIT  - held while power-down pin high
  //   DELAY - power-on delay, short or long
  //   CAL   - calibration for CAL_LEN cycles
  //   RUN   - normal operation
  // A power-down raised during CAL is latched
  // and applied in the first RUN cycle.
  // Manual requests are only honoured in RUN
  // while powered up; in power-down they are
  // dropped, never queued.
  // Limitation: a power-down during DELAY is
  // not deferred, calibration still follows.
  // Q channel calibration flag is set when a calibration
  // ends with Q powered, cleared when Q powers down in RUN.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q  <= ST_WAIT;
      cnt_q    <= '0;
      pd_q     <= 1'b1;
      pend_q   <= 1'b0;
      cal_done <= 1'b0;
      q_calibrated <= 1'b0;
    end else begin
      cal_done <= 1'b0;
      unique case (state_q)
        ST_WAIT: begin
          // Power-on calibration held while power-down is high
          if (!power_down_pin) begin
            state_q <= ST_DELAY;
            pd_q    <= 1'b0;
            // Extended mode always takes the short delay
            cnt_q   <= (!ext && cal_delay_des_pin) ? CNT_W'(LONG_DLY - 1) : CNT_W'(SHORT_DLY - 1);
          end
        end
        ST_DELAY: begin
          if (cnt_q == '0) begin
            state_q <= ST_CAL;
            cnt_q   <= CNT_W'(CAL_LEN - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_CAL: begin
          if (power_down_pin) pend_q <= 1'b1;
          if (cnt_q == '0) begin
            state_q  <= ST_RUN;
            cal_done <= 1'b1;
            // Q trims only refreshed when Q was up
            q_calibrated <= !q_channel_power_down;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_RUN: begin
          if (pend_q || power_down_pin) begin
            pd_q   <= 1'b1;
            pend_q <= 1'b0;
          end else if (!pd_q && cal_request) begin
            state_q <= ST_CAL;
            cnt_q   <= CNT_W'(CAL_LEN - 1);
          end else if (pd_q) begin
            pd_q <= 1'b0; // Released; pipeline contents invalid
          end
          if (q_channel_power_down) q_calibrated <= 1'b0;
          // Powered down: requests ignored, not queued
          if (pd_q && power_down_pin) pend_q <= 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Power outputs
  // ----------------------------------------
  // I follows the global power state only;
  // Q also drops with its own power-down pin.
  // Data output enable is high while driven;
  // clock and range pairs switch to the weak
  // pull-down instead of tri-state.
  // One cycle lag behind the sequencer is
  // harmless for static pins.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      active          <= 1'b0;
      i_powered       <= 1'b0;
      q_powered       <= 1'b0;
      data_oe         <= 1'b0;
      clk_or_pulldown <= 1'b1;
      cal_busy        <= 1'b0;
    end else begin
      active          <= !pd_q;
      i_powered       <= !pd_q;
      q_powered       <= !pd_q && !q_channel_power_down;
      data_oe         <= !pd_q;
      clk_or_pulldown <= pd_q;
      cal_busy        <= (state_q == ST_CAL);
    end
  end
  // ----------------------------------------
  // Mode-dependent feature sources
  // ----------------------------------------
  // Extended mode: every feature from registers.
  // Normal mode: features from pins, with the
  // fixed values that normal mode implies:
  //   phase always zero degrees
  //   no offset or per-channel range trim
  //   dual-edge input is always I
  //   dual-edge phase always automatic
  // The range pin doubles as the mode select,
  // so range_high is only meaningful in normal
  // mode and held low in extended mode.
  // The delay pin doubles as dual-edge enable
  // in normal mode, a pin-count trade-off.
  // Mode is assumed fixed while running, so no
  // hand-over logic exists between the sources.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      double_rate          <= 1'b1;
      ddr_phase_90         <= 1'b0;
      rising_edge_out      <= 1'b0;
      swing_high           <= 1'b1;
      range_high           <= 1'b0;
      i_range_trim         <= 9'h0;
      q_range_trim         <= 9'h0;
      i_offset_trim        <= 9'h0;
      q_offset_trim        <= 9'h0;
      dual_edge_on         <= 1'b0;
      dual_edge_q_input    <= 1'b0;
      dual_edge_auto_phase <= 1'b1;
      dual_edge_coarse     <= 16'h0;
      dual_edge_fine       <= 16'h0;
    end else if (ext) begin
      double_rate          <= !cfg_q[B_NDDR];
      ddr_phase_90         <= cfg_q[B_PHASE];
      rising_edge_out      <= cfg_q[B_EDGE];
      swing_high           <= cfg_q[B_SWING];
      range_high           <= 1'b0;
      i_range_trim         <= trim(ifs_q);
      q_range_trim         <= trim(qfs_q);
      i_offset_trim        <= trim(ioff_q);
      q_offset_trim        <= trim(qoff_q);
      dual_edge_on         <= den_q[B_DE_ON];
      dual_edge_q_input    <= den_q[B_DE_QSEL];
      dual_edge_auto_phase <= den_q[B_DE_AUTO];
      dual_edge_coarse     <= dcrs_q;
      dual_edge_fine       <= dfin_q;
    end else begin
      double_rate          <= ddr_pin_float;
      ddr_phase_90         <= 1'b0;
      rising_edge_out      <= edge_pin;
      swing_high           <= output_swing_select;
      range_high           <= range_or_ext_ctrl_select;
      i_range_trim         <= 9'h0;
      q_range_trim         <= 9'h0;
      i_offset_trim        <= 9'h0;
      q_offset_trim        <= 9'h0;
      dual_edge_on         <= cal_delay_des_pin;
      dual_edge_q_input    <= 1'b0;
      dual_edge_auto_phase <= 1'b1;
      dual_edge_coarse     <= 16'h0;
      dual_edge_fine       <= 16'h0;
    end
  end
endmodule
`default_nettype wire

// *** dv/pdc_ctrl_props.sv ***
/* Concurrent checks on the power-down and control-mode ports.
   Bound into pdc_ctrl; sees only its top-level ports. */
`timescale 1ns/1ps
`default_nettype none
module pdc_ctrl_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_down_pin,
  input wire logic q_channel_power_down,
  input wire logic ext_select_float,
  input wire logic ddr_pin_float,
  input wire logic edge_pin,
  input wire logic output_swing_select,
  input wire logic active,
  input wire logic i_powered,
  input wire logic q_powered,
  input wire logic data_oe,
  input wire logic clk_or_pulldown,
  input wire logic cal_busy,
  input wire logic cal_done,
  input wire logic double_rate,
  input wire logic ddr_phase_90,
  input wire logic rising_edge_out,
  input wire logic swing_high,
  input wire logic dual_edge_q_input
);
  // --------------------------------------
  // Power sequencing and pin-mode checks
  // --------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_down_data_off: assert property (!active |-> !data_oe)
    else $error("data driven while powered down");
  chk_down_pulldown: assert property (!active |-> clk_or_pulldown)
    else $error("clock pair not pulled down");
  chk_q_only_off: assert property ((q_channel_power_down && active)[*3] |-> !q_powered && i_powered)
    else $error("q power-down wrong channel");
  chk_cal_keeps_up: assert property (cal_busy |-> active)
    else $error("powered down during calibration");
  chk_pd_after_cal: assert property (cal_done && power_down_pin |-> ##[1:2] !active)
    else $error("pending power-down not applied");
  chk_no_cal_down: assert property (power_down_pin && !active && !cal_busy |=> !cal_busy)
    else $error("calibration started while down");
  chk_phase_normal: assert property (!ext_select_float |-> !ddr_phase_90)
    else $error("phase not zero in normal mode");
  chk_ddr_from_pin: assert property ((!ext_select_float && ddr_pin_float)[*3] |-> double_rate)
    else $error("double rate ignores pin");
  chk_edge_from_pin: assert property ((!ext_select_float && edge_pin)[*3] |-> rising_edge_out)
    else $error("output edge ignores pin");
  chk_swing_from_pin: assert property ((!ext_select_float && !output_swing_select)[*3] |-> !swing_high)
    else $error("swing ignores pin");
  chk_des_i_only: assert property (!ext_select_float |-> !dual_edge_q_input)
    else $error("q input chosen in normal mode");
endmodule
bind pdc_ctrl pdc_ctrl_props pdc_ctrl_props_i (.*);
`default_nettype wire

// *** dv/pdc_host_model.sv ***
/* Host controller model: static control pins and serial register writes.
   Driven by bench task calls; changes everything on the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module pdc_host_model (
  input  wire logic clock,
  output wire logic power_down_pin,
  output wire logic q_channel_power_down,
  output wire logic range_or_ext_ctrl_select,
  output wire logic ext_select_float,
  output wire logic ddr_pin_float,
  output wire logic edge_pin,
  output wire logic output_swing_select,
  output wire logic cal_delay_des_pin,
  output wire logic cal_request,
  output var  logic ser_clk,
  output var  logic ser_data,
  output var  logic ser_sel_n
);
  // ----------------------
  // Pin levels
  // ----------------------
  logic [8:0] p = 9'h000; // Static pin image
  // No sample data consumed after power-up; pipeline is stale
  assign {power_down_pin, q_channel_power_down, range_or_ext_ctrl_select, ext_select_float,
          ddr_pin_float, edge_pin, output_swing_select, cal_delay_des_pin, cal_request} = p;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_sel_n = 1'b1;
  end
  // Mode pin only moved by the bench under reset
  task automatic pin(input int n, input logic v);
    @(negedge clock);
    p[n] = v;
  endtask
  // ----------------------
  // Serial frame writer
  // ----------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] f;
    f = {12'h001, a, d};
    for (int i = 31; i >= 0; i--) begin
      @(negedge clock);
      ser_sel_n = 1'b0;
      ser_clk = 1'b0;
      ser_data = f[i];
      repeat (2) @(negedge clock);
      ser_clk = 1'b1;
      repeat (2) @(negedge clock);
    end
    @(negedge clock);
    ser_clk = 1'b0;
    ser_sel_n = 1'b1;
    ser_data = ~ser_data; // Released line: no stale level
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
/* Self-checking bench for pdc_ctrl with short sim counts 8/4/16.
   Host model drives pins and serial frames; checker bound separately. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PD = 8, Q_CHANNEL_POWER_DOWN = 7, RNG = 6, EXT = 5, DDR = 4, EDG = 3, SWG = 2, DLY = 1, CAL = 0;
  logic clock;
  logic rst_n = 1'b0;
  wire power_down_pin, q_channel_power_down, range_or_ext_ctrl_select, ext_select_float;
  wire ddr_pin_float, edge_pin, output_swing_select, cal_delay_des_pin, cal_request;
  wire ser_clk, ser_data, ser_sel_n;
  logic active, i_powered, q_powered, data_oe, clk_or_pulldown, cal_busy, cal_done, q_calibrated;
  logic double_rate, ddr_phase_90, rising_edge_out, swing_high, range_high;
  logic dual_edge_on, dual_edge_q_input, dual_edge_auto_phase;
  logic [8:0] i_range_trim, q_range_trim, i_offset_trim, q_offset_trim;
  logic [15:0] dual_edge_coarse, dual_edge_fine;
  int n_errors = 0;
  int n_checks = 0;
  int n;
  logic b;
  pdc_ctrl #(.CAL_LEN(8), .SHORT_DLY(4), .LONG_DLY(16)) pdc_ctrl_i (.*);
  pdc_host_model pdc_host_model_i (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----------------------
  // Shared tasks
  // ----------------------
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic reset(input logic ext);
    rst_n = 1'b0;
    pdc_host_model_i.pin(EXT, ext);
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
  endtask
  // Bounded wait for the calibration pulse; counts cycles taken
  task automatic wait_done(output int k);
    k = 0;
    while (cal_done !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    if (k >= 200) begin
      n_errors++;
      $display("Error cal_done timeout");
      complete_run();
    end
  endtask
  task automatic pulse_cal;
    pdc_host_model_i.pin(CAL, 1'b1);
    pdc_host_model_i.pin(CAL, 1'b0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    pdc_host_model_i.wr(a, d);
    repeat (6) @(negedge clock);
  endtask
  // ----------------------
  // Main sequence
  // ----------------------
  initial begin
    pdc_host_model_i.pin(PD, 1'b1);
    pdc_host_model_i.pin(DLY, 1'b1);
    pdc_host_model_i.pin(DDR, 1'b1);
    pdc_host_model_i.pin(EDG, 1'b1);
    reset(1'b0);
    pulse_cal();
    b = 1'b0;
    repeat (30) begin
      @(negedge clock);
      b = b | cal_busy;
    end
    chk("cal_busy", 16'(b), 16'h0000);
    chk("active", 16'(active), 16'h0000);
    chk("data_oe", 16'(data_oe), 16'h0000);
    chk("pulldown", 16'(clk_or_pulldown), 16'h0001);
    pdc_host_model_i.pin(PD, 1'b0);
    wait_done(n);
    chk("long_delay", 16'(n >= 24 && n <= 30), 16'h0001);
    repeat (3) @(negedge clock);
    chk("data_oe", 16'(data_oe), 16'h0001);
    chk("pulldown", 16'(clk_or_pulldown), 16'h0000);
    chk("double_rate", 16'(double_rate), 16'h0001);
    chk("rising", 16'(rising_edge_out), 16'h0001);
    chk("swing", 16'(swing_high), 16'h0000);
    chk("range", 16'(range_high), 16'h0000);
    chk("des_on", 16'(dual_edge_on), 16'h0001);
    chk("des_auto", 16'(dual_edge_auto_phase), 16'h0001);
    wr(4'h1, 16'hB8FF);
    chk("phase", 16'(ddr_phase_90), 16'h0000);
    pdc_host_model_i.pin(RNG, 1'b1);
    pdc_host_model_i.pin(SWG, 1'b1);
    repeat (3) @(negedge clock);
    chk("range", 16'(range_high), 16'h0001);
    chk("swing", 16'(swing_high), 16'h0001);
    pdc_host_model_i.pin(Q_CHANNEL_POWER_DOWN, 1'b1);
    repeat (3) @(negedge clock);
    chk("q_pow", 16'({q_powered, i_powered}), 16'h0001);
    pulse_cal();
    wait_done(n);
    repeat (2) @(negedge clock);
    chk("q_cal", 16'(q_calibrated), 16'h0000);
    pdc_host_model_i.pin(Q_CHANNEL_POWER_DOWN, 1'b0);
    pulse_cal(); // Fresh calibration before Q is used
    wait_done(n);
    repeat (2) @(negedge clock);
    chk("q_cal", 16'(q_calibrated), 16'h0001);
    pulse_cal();
    pdc_host_model_i.pin(PD, 1'b1);
    wait_done(n);
    chk("active", 16'(active), 16'h0001);
    repeat (3) @(negedge clock);
    chk("active", 16'(active), 16'h0000);
    pdc_host_model_i.pin(PD, 1'b0);
    pdc_host_model_i.pin(SWG, 1'b0);
    pdc_host_model_i.pin(DDR, 1'b0);
    reset(1'b1);
    wait_done(n);
    chk("short_delay", 16'(n >= 12 && n <= 18), 16'h0001);
    repeat (3) @(negedge clock);
    chk("defaults", 16'({double_rate, ddr_phase_90, dual_edge_on, swing_high}), 16'h0009);
    wr(4'h1, 16'hB8FF);
    chk("cfg_a", 16'({double_rate, ddr_phase_90, swing_high}), 16'h0006);
    wr(4'h1, 16'hB5FF);
    chk("cfg_b", 16'({double_rate, rising_edge_out}), 16'h0001);
    wr(4'h2, 16'hFF80);
    wr(4'hA, 16'h0080);
    chk("offsets", 16'({q_offset_trim[1:0], i_offset_trim}), 16'h03FF);
    wr(4'h3, 16'h0100);
    wr(4'hB, 16'hFF80);
    chk("ranges", 16'({q_range_trim[1:0], i_range_trim}), 16'h0602);
    wr(4'hD, 16'hE000);
    chk("des", 16'({dual_edge_on, dual_edge_auto_phase, dual_edge_q_input}), 16'h0007);
    wr(4'hD, 16'h8000);
    chk("des_auto", 16'(dual_edge_auto_phase), 16'h0000);
    wr(4'hE, 16'h1234);
    wr(4'hF, 16'h00AB);
    chk("coarse", dual_edge_coarse, 16'h1234);
    chk("fine", dual_edge_fine, 16'h00AB);
    wr(4'h4, 16'hFFFF);
    chk("reserved", 16'(i_range_trim), 16'h0002);
    complete_run();
  end
endmodule
`default_nettype wire
